/* File: src/lrc_pkg.sv */
package lrc_pkg;
  localparam longint LRC_CLK_HZ       = 25000000;
  // frequencies are held in units of 0.1 mHz
  localparam longint LRC_UNITS_PER_HZ = 10000;
  localparam longint LRC_FMAX_HZ      = 102000;
  localparam longint LRC_FMIN_MHZ     = 1;
  localparam logic [29:0] LRC_F_MAX   = 30'(LRC_FMAX_HZ * LRC_UNITS_PER_HZ);
  localparam logic [29:0] LRC_F_MIN   = 30'(LRC_FMIN_MHZ * LRC_UNITS_PER_HZ / 1000);
  localparam logic [29:0] LRC_F_RESET = 30'(1000 * LRC_UNITS_PER_HZ);
  localparam logic [14:0] LRC_HARM_MAX = 15'd19999;
  localparam logic [14:0] LRC_HARM_ONE = 15'd1;
  // phase is held in units of 0.01 degree
  localparam logic signed [17:0] LRC_PH_LIM  = 18'sd18000;
  localparam logic signed [17:0] LRC_PH_TURN = 18'sd36000;
  localparam logic signed [17:0] LRC_PH_QTR  = 18'sd9000;
  // 2^32 / 36000: phase units to a 16-bit binary angle after a 16-bit shift
  localparam logic [17:0] LRC_PH_TO_BIN = 18'd119305;
  // 2^64 / (clock rate in frequency units): frequency to 48-bit nco step after a 16-bit shift
  localparam logic [26:0] LRC_NCO_K     = 27'd73786976;
  localparam logic [37:0] LRC_NCO_TO_F  = 38'(LRC_CLK_HZ * LRC_UNITS_PER_HZ);
  localparam logic [35:0] LRC_PER_MIN   = 36'(LRC_CLK_HZ / LRC_FMAX_HZ);
  localparam longint LRC_PER_MAX_DEF    = LRC_CLK_HZ * 1000 / LRC_FMIN_MHZ;
  localparam longint LRC_BLINK_MS       = 250;
  localparam longint LRC_BLINK_DEF      = LRC_CLK_HZ / 1000 * LRC_BLINK_MS;
  localparam logic [48:0] LRC_DIV_ONE   = 49'h1000000000000;
  localparam logic [5:0] LRC_DIV_STEPS  = 6'h30;
  // register offsets
  localparam logic [7:0] LRC_A_CTRL   = 8'h00;
  localparam logic [7:0] LRC_A_PHASE  = 8'h04;
  localparam logic [7:0] LRC_A_FREQ   = 8'h08;
  localparam logic [7:0] LRC_A_HARM   = 8'h0c;
  localparam logic [7:0] LRC_A_CMD    = 8'h10;
  localparam logic [7:0] LRC_A_STATUS = 8'h14;
  // field positions
  localparam int LRC_CTRL_INT   = 0;
  localparam int LRC_CTRL_TRIG  = 1;
  localparam int LRC_CTRL_STORE = 3;
  localparam int LRC_CMD_AUTO   = 0;
  localparam int LRC_CMD_PLUS   = 1;
  localparam int LRC_CMD_MINUS  = 2;
  localparam int LRC_ST_UNLOCK  = 0;
  localparam int LRC_ST_OVER    = 1;
  localparam int LRC_ST_BAD     = 2;
  localparam int LRC_ST_INT     = 3;
  localparam int LRC_ST_HARM    = 4;
  localparam int LRC_ST_BUSY    = 5;
  typedef enum logic [1:0] {
    LRC_SINE_LOCK_MODE         = 2'b00,
    LRC_RISING_EDGE_LOCK_MODE  = 2'b01,
    LRC_FALLING_EDGE_LOCK_MODE = 2'b10
  } lrc_trig_t;
  typedef enum logic {
    LRC_DS_IDLE = 1'b0,
    LRC_DS_DIV  = 1'b1
  } lrc_dstate_t;
endpackage : lrc_pkg

/* File: src/lrc_top.sv */
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
//Contract
//(R01) unlock indicator when external lock fails
//(R02) trigger pulse only when storage uses trigger
//(R03) phase held in -180..+180, 0.01 step
//(R04) phase shifts only internal detector sines
//(R05) auto phase subtracts angle; abort if unstable
//(R06) quarter keys add or subtract 90 degrees
//(R07) both quarter keys clear phase to zero
//(R08) external mode reports measured freq, ignores adjust
//(R09) external too fast for harmonic: harmonic to one
//(R10) internal frequency 0.001 Hz to 102 kHz
//(R11) internal frequency capped at top over harmonic
//(R12) sync output from sine zero crossings
//(R13) detector runs at harmonic multiple of reference
//(R14) harmonic indicator flashes when harmonic above one
//(R15) harmonic up to 19999 within frequency limit
//(R16) reject harmonic over range and flag it
//(R17) default external; internal indicator when internal
//(R18) external lock range 0.001 Hz to 102 kHz
//(R19) internal mode ignores reference input entirely
//(R20) edge modes lock to chosen logic edge
//(R21) sine mode locks to rising zero crossings
//(R22) source gives logic edges below 1 Hz
//(R23) key and auto phase results wrap into range
module lrc_top
  import lrc_pkg::*;
#(
  parameter longint PER_MAX   = LRC_PER_MAX_DEF,
  parameter longint BLINK_CYC = LRC_BLINK_DEF
) (
  input  wire logic               clk,
  input  wire logic               resetn,
  input  wire logic [7:0]         addr,
  input  wire logic [31:0]        wdata,
  input  wire logic               wr,
  input  wire logic               rd,
  output logic [31:0]             rdata,
  input  wire logic               ref_ttl_in,
  input  wire logic               ref_sine_cmp_in,
  input  wire logic               trig_in,
  input  wire logic               key_plus90,
  input  wire logic               key_minus90,
  input  wire logic signed [15:0] theta,
  input  wire logic               theta_stable,
  output logic [15:0]             phase_sensitive_detector_phase,
  output logic                    sync_out,
  output logic                    unlock_led,
  output logic                    trig_led,
  output logic                    internal_led,
  output logic                    harm_led,
  output logic                    harmonic_overrange_message
);

  typedef struct packed {
    logic [2:0]         ref_s;
    logic [2:0]         sin_s;
    logic [2:0]         trg_s;
    logic [2:0]         kp_s;
    logic [2:0]         km_s;
    logic               internal;
    lrc_trig_t          trig_mode;
    logic               store_en;
    logic signed [15:0] phase;
    logic [29:0]        freq_set;
    logic [14:0]        harm;
    logic [47:0]        acc;
    logic [47:0]        ext_inc;
    logic [35:0]        per_cnt;
    logic [1:0]         edges;
    logic               locked;
    logic               over;
    logic               bad;
    lrc_dstate_t        dst;
    logic               job_cap;
    logic [5:0]         dcnt;
    logic [48:0]        dnum;
    logic [35:0]        dden;
    logic [36:0]        drem;
    logic [31:0]        rdata;
    logic [15:0]        det;
    logic               sync;
    logic               trig_p;
    logic [31:0]        blink_cnt;
    logic               blink;
  } lrc_state_t;

  localparam lrc_state_t LRC_ST_RST = '{
    trig_mode: LRC_SINE_LOCK_MODE,
    dst:       LRC_DS_IDLE,
    harm:      LRC_HARM_ONE,
    freq_set:  LRC_F_RESET,
    default:   '0
  };

  localparam logic [35:0] PER_MAX_C   = 36'(PER_MAX);
  localparam logic [31:0] BLINK_LAST  = 32'(BLINK_CYC - 1);

  lrc_state_t s;
  lrc_state_t n;

  logic               ref_rise;
  logic               ref_fall;
  logic               sin_rise;
  logic               trg_rise;
  logic               kp_rise;
  logic               km_rise;
  logic               edge_sel;
  logic               ext_edge;
  logic               cmd_wr;
  logic               q_plus;
  logic               q_minus;
  logic               q_both;
  logic [36:0]        rm;
  logic [85:0]        mf_full;
  logic [29:0]        meas_f;
  logic [29:0]        ref_f;
  logic [29:0]        fw;
  logic [44:0]        prod_f;
  logic [44:0]        prod_w;
  logic [44:0]        prod_h;
  logic [56:0]        nco_full;
  logic [47:0]        inc;
  logic signed [34:0] pb;
  logic [30:0]        hp;
  logic signed [17:0] pv;
  logic signed [17:0] tv;
  logic [31:0]        rd_mux;

  function automatic logic signed [15:0] lrc_wrap(input logic signed [17:0] v);
    logic signed [17:0] w;
    w = v;
    if (v > LRC_PH_LIM) begin
      w = v - LRC_PH_TURN;
    end else if (v < -LRC_PH_LIM) begin
      w = v + LRC_PH_TURN;
    end
    return w[15:0];
  endfunction : lrc_wrap

  always_comb begin
    n = s;
    // first flop takes the pin; only the second and third are read
    n.ref_s = {s.ref_s[1:0], ref_ttl_in};
    n.sin_s = {s.sin_s[1:0], ref_sine_cmp_in};
    n.trg_s = {s.trg_s[1:0], trig_in};
    n.kp_s  = {s.kp_s[1:0], key_plus90};
    n.km_s  = {s.km_s[1:0], key_minus90};
    ref_rise = s.ref_s[1] & ~s.ref_s[2];
    ref_fall = ~s.ref_s[1] & s.ref_s[2];
    sin_rise = s.sin_s[1] & ~s.sin_s[2];
    trg_rise = s.trg_s[1] & ~s.trg_s[2];
    kp_rise  = s.kp_s[1] & ~s.kp_s[2];
    km_rise  = s.km_s[1] & ~s.km_s[2];

    unique case (s.trig_mode)
      LRC_SINE_LOCK_MODE:         edge_sel = sin_rise;  // [R21]
      LRC_RISING_EDGE_LOCK_MODE:  edge_sel = ref_rise;  // [R20]
      LRC_FALLING_EDGE_LOCK_MODE: edge_sel = ref_fall;  // [R20]
      default:                    edge_sel = 1'b0;
    endcase
    ext_edge = ~s.internal & edge_sel;  // [R19]

    // measured frequency from the locked nco step
    mf_full = 86'(s.ext_inc) * 86'(LRC_NCO_TO_F);
    meas_f  = mf_full[77:48];  // [R08]
    ref_f   = s.internal ? s.freq_set : (s.locked ? meas_f : 30'h0);
    prod_f  = 45'(ref_f) * 45'(s.harm);

    // shared serial divider: nco step from period, or frequency cap
    rm = 37'h0;
    if (s.dst == LRC_DS_DIV) begin
      rm = {s.drem[35:0], s.dnum[48]};
      n.dnum = {s.dnum[47:0], 1'b0};
      if (rm >= {1'b0, s.dden}) begin
        rm = rm - {1'b0, s.dden};
        n.dnum[0] = 1'b1;
      end
      n.drem = rm;
      n.dcnt = s.dcnt - 6'h1;
      if (s.dcnt == 6'h0) begin
        n.dst = LRC_DS_IDLE;
        if (s.job_cap) begin
          n.freq_set = n.dnum[29:0];  // [R11]
        end else begin
          n.ext_inc = n.dnum[47:0];
        end
      end
    end

    // external period measurement and lock state
    if (s.internal) begin
      n.per_cnt = 36'h0;  // [R19]
      n.edges   = 2'h0;
      n.locked  = 1'b0;
    end else if (ext_edge) begin
      n.per_cnt = 36'h0;
      if (s.edges != 2'h0 && s.per_cnt >= LRC_PER_MIN) begin  // [R18]
        n.edges   = 2'h2;
        n.locked  = 1'b1;
        n.dst     = LRC_DS_DIV;
        n.job_cap = 1'b0;
        n.dcnt    = LRC_DIV_STEPS;
        n.dnum    = LRC_DIV_ONE;
        n.dden    = s.per_cnt + 36'h1;
        n.drem    = 37'h0;
      end else begin
        n.edges  = 2'h1;
        n.locked = 1'b0;  // [R01]
      end
    end else if (s.per_cnt > PER_MAX_C) begin
      n.edges  = 2'h0;  // [R18]
      n.locked = 1'b0;  // [R01]
    end else begin
      n.per_cnt = s.per_cnt + 36'h1;
    end

    // tracked reference too fast for the harmonic: fall back to the fundamental
    if (~s.internal && s.locked && s.harm > LRC_HARM_ONE && prod_f > 45'(LRC_F_MAX)) begin
      n.harm = LRC_HARM_ONE;  // [R09]
    end

    // reference oscillator; reset to zero phase on each locking edge
    nco_full = 57'(s.freq_set) * 57'(LRC_NCO_K);
    inc = s.internal ? 48'(nco_full[56:16]) : s.ext_inc;
    n.acc = ext_edge ? 48'h0 : s.acc + inc;  // [R18]
    n.sync = ~s.acc[47];  // [R12]

    // detector angle: harmonic multiple plus the phase shift
    hp = 31'(s.acc[47:32]) * 31'(s.harm);
    pb = 35'(s.phase) * $signed({17'h0, LRC_PH_TO_BIN});
    n.det = hp[15:0] + 16'(pb[31:16]);  // [R13] [R04]

    // trigger indicator only while storage follows the trigger
    n.trig_p = trg_rise & s.store_en;  // [R02]

    // slow blink for the harmonic indicator
    if (s.blink_cnt == BLINK_LAST) begin
      n.blink_cnt = 32'h0;
      n.blink = ~s.blink;
    end else begin
      n.blink_cnt = s.blink_cnt + 32'h1;
    end

    // quarter-turn keys from the panel or the command register
    cmd_wr  = wr && addr == LRC_A_CMD;
    q_plus  = kp_rise | (cmd_wr & wdata[LRC_CMD_PLUS]);
    q_minus = km_rise | (cmd_wr & wdata[LRC_CMD_MINUS]);
    q_both  = (kp_rise | km_rise) & s.kp_s[1] & s.km_s[1];
    q_both  = q_both | (cmd_wr & wdata[LRC_CMD_PLUS] & wdata[LRC_CMD_MINUS]);
    // both keys together win over either one alone
    pv = 18'(s.phase);
    tv = 18'(theta);
    if (q_both) begin
      n.phase = 16'sh0;  // [R07]
    end else if (q_plus) begin
      n.phase = lrc_wrap(pv + LRC_PH_QTR);  // [R06] [R23]
    end else if (q_minus) begin
      n.phase = lrc_wrap(pv - LRC_PH_QTR);  // [R06] [R23]
    end

    // status clears first so a same-cycle event wins
    if (wr && addr == LRC_A_STATUS) begin
      if (wdata[LRC_ST_OVER]) begin
        n.over = 1'b0;
      end
      if (wdata[LRC_ST_BAD]) begin
        n.bad = 1'b0;
      end
    end

    if (cmd_wr && wdata[LRC_CMD_AUTO]) begin
      if (theta_stable) begin
        n.phase = lrc_wrap(pv - tv);  // [R05] [R23]
      end else begin
        n.bad = 1'b1;  // [R05]
      end
    end

    // register writes; a frequency write only counts in internal mode
    fw = wdata[29:0];
    prod_w = 45'h0;
    prod_h = 45'(ref_f) * 45'(wdata[14:0]);
    if (wr) begin
      unique case (addr)
        LRC_A_CTRL: begin
          n.internal = wdata[LRC_CTRL_INT];  // [R17]
          n.store_en = wdata[LRC_CTRL_STORE];
          unique case (wdata[LRC_CTRL_TRIG +: 2])
            2'h1:    n.trig_mode = LRC_RISING_EDGE_LOCK_MODE;
            2'h2:    n.trig_mode = LRC_FALLING_EDGE_LOCK_MODE;
            default: n.trig_mode = LRC_SINE_LOCK_MODE;
          endcase
        end
        LRC_A_PHASE: begin
          pv = 18'($signed(wdata[15:0]));
          if (wdata[31:16] != {16{wdata[15]}}) begin
            pv = wdata[31] ? -LRC_PH_LIM : LRC_PH_LIM;
          end
          if (pv > LRC_PH_LIM) begin
            pv = LRC_PH_LIM;  // [R03]
          end else if (pv < -LRC_PH_LIM) begin
            pv = -LRC_PH_LIM;  // [R03]
          end
          n.phase = pv[15:0];
        end
        LRC_A_FREQ: begin
          if (s.internal) begin  // [R08]
            if (wdata[31:30] != 2'h0 || fw > LRC_F_MAX) begin
              fw = LRC_F_MAX;  // [R10]
            end else if (fw < LRC_F_MIN) begin
              fw = LRC_F_MIN;  // [R10]
            end
            prod_w = 45'(fw) * 45'(s.harm);
            if (prod_w > 45'(LRC_F_MAX)) begin
              n.dst     = LRC_DS_DIV;  // [R11]
              n.job_cap = 1'b1;
              n.dcnt    = LRC_DIV_STEPS;
              n.dnum    = 49'(LRC_F_MAX);
              n.dden    = 36'(s.harm);
              n.drem    = 37'h0;
            end else begin
              n.freq_set = fw;
            end
          end
        end
        LRC_A_HARM: begin
          if (wdata[31:15] != 17'h0 || wdata[14:0] == 15'h0 || wdata[14:0] > LRC_HARM_MAX
              || prod_h > 45'(LRC_F_MAX)) begin
            n.over = 1'b1;  // [R16] [R15]
          end else begin
            n.harm = wdata[14:0];  // [R15]
          end
        end
        default: begin
        end
      endcase
    end

    // read data stand one cycle after the strobe, zero otherwise
    rd_mux = 32'h0;
    unique case (addr)
      LRC_A_CTRL:   rd_mux = {28'h0, s.store_en, s.trig_mode, s.internal};
      LRC_A_PHASE:  rd_mux = 32'(s.phase);
      LRC_A_FREQ:   rd_mux = {2'h0, ref_f};  // [R08]
      LRC_A_HARM:   rd_mux = {17'h0, s.harm};
      LRC_A_STATUS: rd_mux = {26'h0, s.dst == LRC_DS_DIV, s.harm > LRC_HARM_ONE, s.internal,
                              s.bad, s.over, ~s.internal & ~s.locked};
      default:      rd_mux = 32'h0;
    endcase
    n.rdata = rd ? rd_mux : 32'h0;
  end

  // synchronous reset, active low
  always_ff @(posedge clk) begin
    if (!resetn) begin
      s <= LRC_ST_RST;
    end else begin
      s <= n;
    end
  end

  assign rdata                          = s.rdata;
  assign phase_sensitive_detector_phase = s.det;
  assign sync_out                       = s.sync;
  assign unlock_led                     = ~s.internal & ~s.locked;  // [R01]
  assign trig_led                       = s.trig_p;
  assign internal_led                   = s.internal;  // [R17]
  assign harm_led                       = (s.harm > LRC_HARM_ONE) & s.blink;  // [R14]
  assign harmonic_overrange_message     = s.over;  // [R16]

endmodule : lrc_top

/* File: bench/lrc_ref_model.sv */
`timescale 1ns/1ns
module lrc_ref_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic [15:0] half_cyc,
  output logic             ref_ttl,
  output logic             ref_sine
);
  logic [15:0] cnt_reg = 16'h0;
  initial ref_ttl = 1'b0;
  // logic-level edges at every rate; the line rests low while stopped
  always @(posedge clk) begin
    if (!run) begin
      cnt_reg <= 16'h0;
      ref_ttl <= 1'b0;
    end else if (cnt_reg + 16'h1 >= half_cyc) begin
      cnt_reg <= 16'h0;
      ref_ttl <= ~ref_ttl;
    end else begin
      cnt_reg <= cnt_reg + 16'h1;
    end
  end
  // comparator sees the same wave, positive half high
  assign ref_sine = ref_ttl;
endmodule : lrc_ref_model

/* File: bench/lrc_top_sva.sv */
`timescale 1ns/1ns
module lrc_top_chk
  import lrc_pkg::*;
(
  input logic        clk,
  input logic        resetn,
  input logic [7:0]  addr,
  input logic [31:0] wdata,
  input logic        wr,
  input logic        rd,
  input logic [31:0] rdata,
  input logic        trig_in,
  input logic        unlock_led,
  input logic        trig_led,
  input logic        internal_led,
  input logic        harmonic_overrange_message
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  sequence s_int_wr;
    wr && addr == LRC_A_CTRL && wdata[LRC_CTRL_INT];
  endsequence
  sequence s_bad_harm;
    wr && addr == LRC_A_HARM && (wdata == 32'h0 || wdata > 32'h4e1f);
  endsequence
  // flag set and no clear of it on this edge
  sequence s_keep_over;
    harmonic_overrange_message && !(wr && addr == LRC_A_STATUS && wdata[LRC_ST_OVER]);
  endsequence
  AST_RDATA_IDLE: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data not zero outside a read answer");
  AST_TRIG_ONE: assert property (trig_led |=> !trig_led)
    else $error("trigger pulse longer than one cycle");
  AST_TRIG_CAUSE: assert property (trig_led |-> $past(trig_in, 2) || $past(trig_in, 3) || $past(trig_in, 4))
    else $error("trigger pulse without trigger input");
  AST_INT_NO_UNLOCK: assert property (internal_led |-> !unlock_led)
    else $error("unlock shown in internal mode");
  AST_RESET_EXT: assert property ($rose(resetn) |-> unlock_led && !internal_led)
    else $error("reset state not external");
  AST_INT_SEL: assert property (s_int_wr |-> ##[1:2] internal_led)
    else $error("internal indicator not lit");
  AST_OVER_SET: assert property (s_bad_harm |-> ##[1:2] harmonic_overrange_message)
    else $error("bad harmonic not flagged");
  AST_OVER_STICKY: assert property (s_keep_over |=> harmonic_overrange_message)
    else $error("over-range flag dropped");
endmodule : lrc_top_chk
bind lrc_top lrc_top_chk chk_u (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata, .trig_in, .unlock_led,
  .trig_led, .internal_led, .harmonic_overrange_message);

/* File: bench/lrc_top_tb.sv */
`timescale 1ns/1ns
module lrc_top_tb import lrc_pkg::*;;
  logic               clk = 1'b0, resetn = 1'b0, wr = 1'b0, rd = 1'b0, trig_in = 1'b0;
  logic               kp = 1'b0, km = 1'b0, stab = 1'b0, run = 1'b0, ttl, sine;
  logic [7:0]         addr = 8'h0;
  logic [31:0]        wdata = 32'h0, rdata, got;
  logic signed [15:0] theta = 16'sh0;
  logic [15:0]        half = 16'd250, det;
  logic               sync_out, unlock_led, trig_led, internal_led, harm_led, over, prev;
  integer             num_errors = 0, n_compared = 0, seed = 32'haa5e, ph, k, n, m;
  int                 exp_q[$];
  initial forever #20 clk = ~clk;
  lrc_top #(.PER_MAX(5000), .BLINK_CYC(8)) dut_u (.clk, .resetn, .addr, .wdata, .wr, .rd, .rdata,
    .ref_ttl_in(ttl), .ref_sine_cmp_in(sine), .trig_in, .key_plus90(kp), .key_minus90(km), .theta,
    .theta_stable(stab), .phase_sensitive_detector_phase(det), .sync_out, .unlock_led, .trig_led,
    .internal_led, .harm_led, .harmonic_overrange_message(over));
  lrc_ref_model ref_u (.clk, .run, .half_cyc(half), .ref_ttl(ttl), .ref_sine(sine));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("MISMATCH %s expected %0d seen %0d", nm, e, g);
    end
  endtask : chk
  task automatic wrr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wrr
  task automatic rdo(input logic [7:0] a);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    // data stand in the cycle after the strobe; taken at that cycle's closing edge
    @(posedge clk);
    got = rdata;
  endtask : rdo
  task automatic rc(input logic [7:0] a, input logic [31:0] e, input string nm);
    rdo(a);
    chk(nm, e, got);
  endtask : rc
  task automatic rng(input string nm, input longint lo, input longint hi, input longint v);
    chk(nm, 32'h1, 32'(v >= lo && v <= hi));
  endtask : rng
  task automatic keys(input logic p, input logic q);
    kp <= p;
    km <= q;
    repeat (6) @(posedge clk);
    kp <= 1'b0;
    km <= 1'b0;
    repeat (6) @(posedge clk);
  endtask : keys
  task automatic pulses(output integer c);
    c = 0;
    trig_in <= 1'b1;
    repeat (10) @(posedge clk) c += trig_led;
    trig_in <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulses
  function automatic int wrap(input int p);
    if (p > 18000) return p - 36000;
    if (p < -18000) return p + 36000;
    return p;
  endfunction : wrap
  task automatic wrap_up;
    $display("comparisons %0d mismatches %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : wrap_up
  initial begin
    #(40 * 90000);
    num_errors++;
    wrap_up();
  end
  initial begin
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rc(LRC_A_CTRL, 32'h0, "ctrl");
    rc(LRC_A_FREQ, 32'h0, "freq");
    rc(LRC_A_HARM, 32'h1, "harm");
    rc(LRC_A_STATUS, 32'h1, "status");
    rc(8'h18, 32'h0, "unmapped");
    wrr(LRC_A_PHASE, 32'd20000);
    rc(LRC_A_PHASE, 32'd18000, "phase hi");
    wrr(LRC_A_PHASE, 32'(-20000));
    rc(LRC_A_PHASE, 32'(-18000), "phase lo");
    for (k = 0; k < 12; k++) begin
      ph = $random(seed) % 18001;
      n = $random(seed) % 18001;
      theta <= 16'(n);
      stab <= k[2];
      wrr(LRC_A_PHASE, 32'(ph));
      wrr(LRC_A_CMD, 32'(k % 4 == 3 ? 1 : 2 * (k % 4 + 1)));
      case (k % 4)
        0: ph = wrap(ph + 9000);
        1: ph = wrap(ph - 9000);
        2: ph = 0;
        default: ph = k[2] ? wrap(ph - n) : ph;
      endcase
      exp_q.push_back(ph);
      rc(LRC_A_PHASE, 32'(exp_q.pop_front()), "phase op");
      if (k % 4 == 3) begin
        rc(LRC_A_STATUS, k[2] ? 32'h1 : 32'h5, "bad flag");
        wrr(LRC_A_STATUS, 32'h4);
      end
    end
    wrr(LRC_A_PHASE, 32'd12000);
    keys(1'b1, 1'b0);
    rc(LRC_A_PHASE, 32'(-15000), "key plus");
    keys(1'b0, 1'b1);
    rc(LRC_A_PHASE, 32'd12000, "key minus");
    keys(1'b1, 1'b1);
    rc(LRC_A_PHASE, 32'h0, "key both");
    wrr(LRC_A_HARM, 32'h0);
    rc(LRC_A_STATUS, 32'h3, "over zero");
    chk("over pin", 32'h1, 32'(over));
    wrr(LRC_A_HARM, 32'd20000);
    rc(LRC_A_HARM, 32'h1, "harm max");
    wrr(LRC_A_HARM, 32'd19999);
    rc(LRC_A_HARM, 32'd19999, "harm top");
    rc(LRC_A_STATUS, 32'h13, "harm flag");
    n = 0;
    repeat (20) @(posedge clk) n += harm_led;
    rng("blink", 8, 12, n);
    wrr(LRC_A_STATUS, 32'h2);
    rc(LRC_A_STATUS, 32'h11, "over clear");
    wrr(LRC_A_CTRL, 32'h1);
    run <= 1'b1;
    wrr(LRC_A_FREQ, 32'd10000000);
    repeat (80) @(posedge clk);
    chk("int led", 32'h1, 32'(internal_led));
    chk("unlock int", 32'h0, 32'(unlock_led));
    rc(LRC_A_FREQ, 32'd51002, "cap");
    wrr(LRC_A_HARM, 32'h1);
    wrr(LRC_A_FREQ, 32'd5);
    rc(LRC_A_FREQ, 32'd10, "fmin");
    // slowest oscillator: the angle barely moves across these few cycles
    ph = det;
    wrr(LRC_A_PHASE, 32'd9000);
    repeat (2) @(posedge clk);
    rng("det shift", 16383, 16386, 16'(det - ph));
    wrr(LRC_A_PHASE, 32'h0);
    wrr(LRC_A_HARM, 32'h2);
    repeat (2) @(posedge clk);
    rng("det harm", 0, 3, 16'(det - 2 * ph));
    wrr(LRC_A_HARM, 32'h1);
    wrr(LRC_A_FREQ, 32'd2000000000);
    rc(LRC_A_FREQ, 32'd1020000000, "fmax");
    wrr(LRC_A_HARM, 32'h2);
    rc(LRC_A_HARM, 32'h1, "harm rej");
    rc(LRC_A_STATUS, 32'ha, "over int");
    wrr(LRC_A_STATUS, 32'h2);
    n = 0;
    prev = sync_out;
    repeat (2450) @(posedge clk) begin
      n += (sync_out && !prev);
      prev = sync_out;
    end
    rng("sync", 9, 11, n);
    for (m = 0; m < 3; m++) begin
      wrr(LRC_A_CTRL, 32'((m << 1) | 8));
      run <= 1'b0;
      repeat (5200) @(posedge clk);
      chk("unlock", 32'h1, 32'(unlock_led));
      run <= 1'b1;
      n = 0;
      while (unlock_led === 1'b1 && n < 4000) @(posedge clk) n++;
      chk("lock", 32'h0, 32'(unlock_led));
      wrr(LRC_A_FREQ, 32'd123);
      // the step update follows the locking edge after the divider has run
      repeat (60) @(posedge clk);
      rdo(LRC_A_FREQ);
      rng("meas f", 495000000, 505000000, got);
      chk("still locked", 32'h0, 32'(unlock_led));
    end
    wrr(LRC_A_HARM, 32'h2);
    rc(LRC_A_HARM, 32'h2, "harm ext");
    wrr(LRC_A_HARM, 32'h3);
    rc(LRC_A_HARM, 32'h2, "harm ext rej");
    pulses(n);
    chk("trig on", 32'h1, 32'(n));
    wrr(LRC_A_CTRL, 32'h4);
    pulses(n);
    chk("trig off", 32'h0, 32'(n));
    half <= 16'd200;
    repeat (3000) @(posedge clk);
    rc(LRC_A_HARM, 32'h1, "harm reset");
    wrap_up();
  end
endmodule : lrc_top_tb
